// ==== rtl/aps_adc_power_mode_sequencer.sv ====
// Decided for this implementation: the Avalon-MM interface to the registers and the placing of the registers.
`default_nettype none
//Contract
// - after reset, powered in internal clock mode with strobe high
// - internal reset lasts 100 us; host must not convert meanwhile
// - with chip select low, first one on data input is a start bit
// - data output shifts zeros until the first conversion has happened
// - floating shutdown pin selects external compensation, clock up to 2 MHz
// - shutdown pin high selects internal compensation, clock at most 400 kHz converting
// - shutdown pin low forces full power-down over the mode bits
// - mode bits: 00 full, 01 fast power-down, 10 internal, 11 external clock
// - in software power-down serial interface works, no conversion runs
// - power-down request finishes current conversion in old clock mode first
// - internal mode result can be shifted out after entering power-down
// - start bit wakes from power-down; following byte sets new modes
// - upper mode bit one stays powered, zero powers down after one conversion
// - shutdown pin low aborts conversion at once into full power-down
// - mode bits are bits 1 and 0 of the control byte
// - conversion begins on sclk falling edge after the eighth control bit
module aps_adc_power_mode_sequencer import aps_pkg::*; #(
	parameter int unsigned POR_CYCLES = APS_POR_CYCLES,
	parameter int unsigned FULL_PU_CYCLES = APS_FULL_PU_CYCLES,
	parameter int unsigned EXT_PU_CYCLES = APS_EXT_PU_CYCLES
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// serial pins from the host
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic din,
	output logic dout,
	output logic dout_oe_n,
	output logic conversion_strobe,
	output logic conversion_strobe_oe_n,
	// shutdown pin, level and float detector
	input wire logic shutdown_pin_n,
	input wire logic shutdown_float,
	// power status
	output logic ready,
	output logic full_power_down,
	output logic fast_power_down,
	// avalon-mm register slave
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest
);

	// whole module state
	typedef struct packed {
		aps_pins_t pin_m;
		aps_pins_t pin_s;
		logic sclk_d;
		logic shutdown_pin_n_d;
		logic [APS_CNT_W-1:0] por_cnt;
		logic por_done;
		logic [APS_CNT_W-1:0] pu_cnt;
		logic [APS_CNT_W-1:0] conv_cnt;
		aps_pwr_t pwr;
		aps_conv_t conv;
		logic ext_clk;
		logic pd_req;
		aps_pwr_t pd_target;
		logic rx_active;
		logic [3:0] rx_cnt;
		logic [7:0] rx_byte;
		logic pending;
		logic [7:0] last_ctrl;
		logic [3:0] bits_sent;
		logic [15:0] shreg;
		logic first_conv;
		logic strobe_low;
		logic strobe_oe_n;
		logic dout_oe_n;
		logic [11:0] sample;
		logic ack;
		logic [31:0] rdata;
	} aps_state_t;

	aps_state_t s;
	aps_state_t next_s;
	logic rise;
	logic fall;
	logic cs_lo;
	logic shutdown_pin_n_active;
	logic comp_int;
	logic start_ok;
	logic conv_done;
	logic pd_hi;
	logic pd_lo;
	logic req;
	aps_status_t status;

	// power-up delay from compensation and the state being left
	function automatic logic [APS_CNT_W-1:0] pu_load(input logic internal, input logic from_fast);
		logic [APS_CNT_W-1:0] v;
		v = APS_CNT_W'(EXT_PU_CYCLES);
		if (internal && from_fast) begin
			v = APS_CNT_W'(APS_FAST_PU_CYCLES);
		end else if (internal) begin
			v = APS_CNT_W'(FULL_PU_CYCLES);
		end
		return v;
	endfunction : pu_load

	// pin decode from synchronised samples
	assign rise = s.pin_s.sclk & ~s.sclk_d;
	assign fall = ~s.pin_s.sclk & s.sclk_d;
	assign cs_lo = ~s.pin_s.cs_n;
	assign shutdown_pin_n_active = ~s.pin_s.shutdown_float & ~s.pin_s.shutdown_pin_n;
	assign comp_int = ~s.pin_s.shutdown_float & s.pin_s.shutdown_pin_n;
	assign start_ok = (s.conv == APS_CV_IDLE) || (s.conv == APS_CV_EXT && s.bits_sent >= 4'(APS_B5_SHIFTS));
	assign pd_hi = s.rx_byte[APS_PD_HI_POS];
	assign pd_lo = s.rx_byte[APS_PD_LO_POS];
	assign req = avs_read | avs_write;

	// status word
	always_comb begin
		status = '0;
		status.ready = s.por_done && s.pu_cnt == '0 && s.pwr == APS_PW_ON;
		status.por_done = s.por_done;
		status.pwr = s.pwr;
		status.ext_clock_mode = s.ext_clk;
		status.converting = s.conv != APS_CV_IDLE;
		status.comp_internal = comp_int;
		status.shutdown_active = shutdown_pin_n_active;
		status.first_conv_done = s.first_conv;
	end

	// next-state logic
	always_comb begin
		next_s = s;
		conv_done = 1'b0;
		// two-stage pin synchronisers
		next_s.pin_m = '{cs_n: cs_n, sclk: sclk, din: din, shutdown_pin_n: shutdown_pin_n,
			shutdown_float: shutdown_float};
		next_s.pin_s = s.pin_m;
		next_s.sclk_d = s.pin_s.sclk;
		next_s.shutdown_pin_n_d = shutdown_pin_n_active;
		// power-on reset interval
		if (!s.por_done) begin
			next_s.por_cnt = s.por_cnt + 1'b1;
			if (s.por_cnt == APS_CNT_W'(POR_CYCLES - 1)) begin
				next_s.por_done = 1'b1;
			end
		end
		// power-up delay after a wake
		if (s.pu_cnt != '0) begin
			next_s.pu_cnt = s.pu_cnt - 1'b1;
		end
		// serial receive of the control byte
		if (!cs_lo || !s.por_done || shutdown_pin_n_active) begin
			next_s.rx_active = 1'b0;
			next_s.rx_cnt = '0;
			if (!cs_lo) begin
				next_s.pending = 1'b0;
			end
		end else if (rise) begin
			if (!s.rx_active) begin
				if (s.pin_s.din && start_ok && !s.pending) begin
					next_s.rx_active = 1'b1;
					next_s.rx_cnt = 4'h1;
					next_s.rx_byte = 8'h01;
					if (s.pwr != APS_PW_ON) begin
						next_s.pwr = APS_PW_ON;
						next_s.pu_cnt = pu_load(comp_int, s.pwr == APS_PW_FAST);
					end
				end
			end else begin
				next_s.rx_byte = {s.rx_byte[6:0], s.pin_s.din};
				next_s.rx_cnt = s.rx_cnt + 1'b1;
				if (s.rx_cnt == 4'(APS_CTRL_BITS - 1)) begin
					next_s.rx_active = 1'b0;
					next_s.pending = 1'b1;
				end
			end
		end
		// falling edge: start a conversion or shift data out
		if (fall && cs_lo && s.pending && !shutdown_pin_n_active) begin
			next_s.pending = 1'b0;
			next_s.last_ctrl = s.rx_byte;
			next_s.first_conv = 1'b1;
			next_s.pd_req = ~pd_hi;
			next_s.pd_target = pd_lo ? APS_PW_FAST : APS_PW_FULL;
			if (pd_hi) begin
				next_s.ext_clk = pd_lo;
			end
			// a power-down request keeps the previous clock mode
			if (pd_hi ? pd_lo : s.ext_clk) begin
				next_s.conv = APS_CV_EXT;
				next_s.bits_sent = '0;
				next_s.strobe_low = 1'b0;
				next_s.shreg = {1'b0, s.sample, 3'b000};
			end else begin
				next_s.conv = APS_CV_INT;
				next_s.conv_cnt = APS_CNT_W'(APS_INT_CONV_CYCLES);
				next_s.strobe_low = 1'b1;
			end
		end else if (fall && cs_lo) begin
			next_s.shreg = {s.shreg[14:0], 1'b0};
			if (s.ext_clk) begin
				next_s.strobe_low = 1'b1;
			end
			if (s.conv == APS_CV_EXT) begin
				next_s.bits_sent = s.bits_sent + 1'b1;
				if (s.bits_sent == 4'(APS_EXT_CONV_BITS - 1)) begin
					conv_done = 1'b1;
				end
			end
		end
		// internal conversion clock
		if (s.conv == APS_CV_INT) begin
			next_s.conv_cnt = s.conv_cnt - 1'b1;
			if (s.conv_cnt == APS_CNT_W'(1)) begin
				conv_done = 1'b1;
				next_s.strobe_low = 1'b0;
				next_s.shreg = {1'b0, s.sample, 3'b000};
			end
		end
		// conversion finished: apply a pending power-down
		if (conv_done) begin
			next_s.conv = APS_CV_IDLE;
			if (s.pd_req) begin
				next_s.pwr = s.pd_target;
				next_s.pd_req = 1'b0;
			end
		end
		// hardware shutdown overrides conversion, power state, pending byte and strobe
		if (shutdown_pin_n_active) begin
			next_s.conv = APS_CV_IDLE;
			next_s.pwr = APS_PW_FULL;
			next_s.pd_req = 1'b0;
			next_s.pending = 1'b0;
			next_s.strobe_low = s.ext_clk;
		end else if (s.shutdown_pin_n_d) begin
			next_s.pwr = APS_PW_ON;
			next_s.pu_cnt = pu_load(comp_int, 1'b0);
		end
		// pin enables, low while driving
		next_s.dout_oe_n = s.pin_s.cs_n;
		next_s.strobe_oe_n = s.ext_clk & s.pin_s.cs_n;
		// register slave: data at first edge, commit at second
		next_s.ack = req & ~s.ack;
		if (avs_read && !s.ack) begin
			if (avs_address == APS_REG_STATUS) begin
				next_s.rdata = status;
			end else if (avs_address == APS_REG_SAMPLE) begin
				next_s.rdata = {20'h0_0000, s.sample};
			end else if (avs_address == APS_REG_CTRL) begin
				next_s.rdata = {24'h00_0000, s.last_ctrl};
			end else begin
				next_s.rdata = 32'h0000_0000;
			end
		end
		if (avs_write && s.ack && avs_address == APS_REG_SAMPLE) begin
			if (avs_byteenable[0]) begin
				next_s.sample[7:0] = avs_writedata[7:0];
			end
			if (avs_byteenable[1]) begin
				next_s.sample[11:8] = avs_writedata[11:8];
			end
		end
	end

	// state register
	always_ff @(posedge clk) begin
		if (rst) begin
			next_s_dummy_guard: begin
				s <= '0;
				s.strobe_oe_n <= 1'b0;
				s.dout_oe_n <= 1'b1;
				s.pin_m.cs_n <= 1'b1;
				s.pin_s.cs_n <= 1'b1;
				s.pin_m.shutdown_pin_n <= 1'b1; // idle level, no false shutdown after reset
				s.pin_s.shutdown_pin_n <= 1'b1;
				s.sample <= APS_SAMPLE_RST;
			end
		end else begin
			s <= next_s;
		end
	end

	// outputs
	assign dout = s.shreg[15];
	assign dout_oe_n = s.dout_oe_n;
	assign conversion_strobe = ~s.strobe_low;
	assign conversion_strobe_oe_n = s.strobe_oe_n;
	assign ready = status.ready;
	assign full_power_down = s.pwr == APS_PW_FULL;
	assign fast_power_down = s.pwr == APS_PW_FAST;
	assign avs_readdata = s.rdata;
	assign avs_waitrequest = req & ~s.ack;

endmodule : aps_adc_power_mode_sequencer
`default_nettype wire

// ==== rtl/aps_pkg.sv ====
`default_nettype none
package aps_pkg;
	// clock and timing
	localparam int APS_CLK_PERIOD_NS = 4;
	localparam int APS_POR_TIME_US = 100;
	localparam int APS_POR_CYCLES = (APS_POR_TIME_US * 1000 + APS_CLK_PERIOD_NS - 1) / APS_CLK_PERIOD_NS;
	localparam int APS_FAST_PU_TIME_US = 5;
	localparam int APS_FAST_PU_CYCLES = (APS_FAST_PU_TIME_US * 1000 + APS_CLK_PERIOD_NS - 1) / APS_CLK_PERIOD_NS;
	localparam int APS_FULL_PU_TIME_US = 300;
	localparam int APS_FULL_PU_CYCLES = (APS_FULL_PU_TIME_US * 1000 + APS_CLK_PERIOD_NS - 1) / APS_CLK_PERIOD_NS;
	localparam int APS_EXT_PU_TIME_MS = 20;
	localparam int APS_EXT_PU_CYCLES = (APS_EXT_PU_TIME_MS * 1000000 + APS_CLK_PERIOD_NS - 1) / APS_CLK_PERIOD_NS;
	localparam int APS_INT_CONV_TIME_NS = 7500;
	localparam int APS_INT_CONV_CYCLES = APS_INT_CONV_TIME_NS / APS_CLK_PERIOD_NS;
	localparam int APS_CNT_W = 24;
	localparam int APS_EXT_CONV_BITS = 12;
	localparam int APS_B5_SHIFTS = 7;
	// register map, byte addresses
	localparam logic [3:0] APS_REG_STATUS = 4'h0;
	localparam logic [3:0] APS_REG_SAMPLE = 4'h4;
	localparam logic [3:0] APS_REG_CTRL = 4'h8;
	localparam logic [11:0] APS_SAMPLE_RST = 12'h000;
	// control byte fields
	localparam int APS_PD_HI_POS = 1;
	localparam int APS_PD_LO_POS = 0;
	localparam int APS_CTRL_BITS = 8;
	// power states
	typedef enum logic [1:0] {
		APS_PW_ON,
		APS_PW_FAST,
		APS_PW_FULL
	} aps_pwr_t;
	// conversion states
	typedef enum logic [1:0] {
		APS_CV_IDLE,
		APS_CV_EXT,
		APS_CV_INT
	} aps_conv_t;
	// serial pins as sampled
	typedef struct packed {
		logic cs_n;
		logic sclk;
		logic din;
		logic shutdown_pin_n;
		logic shutdown_float;
	} aps_pins_t;
	// status register layout
	typedef struct packed {
		logic [22:0] zero;
		logic first_conv_done;
		logic shutdown_active;
		logic comp_internal;
		logic converting;
		logic ext_clock_mode;
		aps_pwr_t pwr;
		logic por_done;
		logic ready;
	} aps_status_t;
endpackage : aps_pkg
`default_nettype wire

// ==== verification/aps_sva.sv ====
`default_nettype none
module aps_sva import aps_pkg::*; #(
	parameter int unsigned POR_CYCLES = APS_POR_CYCLES
) (
	// watched ports
	input wire logic clk,
	input wire logic rst,
	input wire logic shutdown_pin_n,
	input wire logic shutdown_float,
	input wire logic conversion_strobe,
	input wire logic ready,
	input wire logic full_power_down,
	input wire logic fast_power_down,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	int unsigned since_rst;
	// cycles since reset release, saturating
	always_ff @(posedge clk) begin
		if (rst) since_rst <= 0;
		else if (since_rst < POR_CYCLES + 100) since_rst <= since_rst + 1;
	end
	a_reset_state: assert property ($fell(rst) |-> conversion_strobe && !full_power_down)
		else $error("strobe low or powered down after reset");
	a_ready_late: assert property (ready |-> since_rst >= POR_CYCLES - 1)
		else $error("ready before power-on delay");
	a_ready_due: assert property (since_rst == POR_CYCLES + 8 && shutdown_pin_n && !shutdown_float |-> ready)
		else $error("ready missing after power-on delay");
	a_shutdown_full: assert property ((!shutdown_pin_n && !shutdown_float) [*4] |-> full_power_down)
		else $error("shutdown pin did not force full power-down");
	a_pd_exclusive: assert property (!(full_power_down && fast_power_down))
		else $error("both power-down modes at once");
	a_ready_powered: assert property (ready |-> !full_power_down && !fast_power_down)
		else $error("ready while powered down");
	a_one_wait: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
		else $error("bus wait not exactly one cycle");
	a_rdata_hold: assert property (!avs_read |=> $stable(avs_readdata))
		else $error("read data changed without a read");
	// main scenarios reached
	cover property ($rose(ready));
	cover property ($rose(full_power_down));
	cover property ($rose(fast_power_down));
endmodule : aps_sva
bind aps_adc_power_mode_sequencer aps_sva #(.POR_CYCLES(POR_CYCLES)) i_sva (.clk, .rst, .shutdown_pin_n,
	.shutdown_float, .conversion_strobe, .ready, .full_power_down, .fast_power_down, .avs_read, .avs_write,
	.avs_readdata, .avs_waitrequest);
`default_nettype wire

// ==== verification/aps_host_model.sv ====
`default_nettype none
module aps_host_model (
	// serial pins toward the device
	output logic cs_n,
	output logic sclk,
	output logic din,
	input wire logic dout
);
	timeunit 1ns;
	timeprecision 100ps;
	// idle: deselected, clock parked low
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		din = 1'b0;
	end
	// one 24-clock frame, msb first, dout taken at each rise
	task automatic xfer(input logic [23:0] tx, output logic [23:0] rx);
		rx = '0;
		cs_n = 1'b0;
		#100;
		for (int i = 0; i < 24; i++) begin
			din = tx[23 - i];
			#62.5 sclk = 1'b1;
			rx = {rx[22:0], dout};
			#62.5 sclk = 1'b0;
		end
		#100 cs_n = 1'b1;
		din = ~din;
	endtask : xfer
endmodule : aps_host_model
`default_nettype wire

// ==== verification/aps_adc_power_mode_sequencer_bench.sv ====
`default_nettype none
module aps_adc_power_mode_sequencer_bench import aps_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [11:0] SMP = 12'ha5c;
	logic clk, rst, cs_n, sclk, din, dout, dout_oe_n, conversion_strobe, conversion_strobe_oe_n;
	logic shutdown_pin_n, shutdown_float, ready, full_power_down, fast_power_down;
	logic avs_read, avs_write, avs_waitrequest;
	logic [3:0] avs_address, avs_byteenable;
	logic [31:0] avs_writedata, avs_readdata, q;
	logic [23:0] rx;
	int failures, tests_run;
	// device with short delays
	aps_adc_power_mode_sequencer #(.POR_CYCLES(20), .FULL_PU_CYCLES(30), .EXT_PU_CYCLES(40)) i_dut (.clk, .rst,
		.cs_n, .sclk, .din, .dout, .dout_oe_n, .conversion_strobe, .conversion_strobe_oe_n, .shutdown_pin_n,
		.shutdown_float, .ready, .full_power_down, .fast_power_down, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest);
	aps_host_model i_host (.cs_n, .sclk, .din, .dout);
	// system clock
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : report_and_stop
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	// one bus cycle, held until waitrequest low
	task automatic bus(input logic wr, input logic [3:0] adr, input logic [31:0] wd);
		avs_address <= adr;
		avs_writedata <= wd;
		avs_read <= ~wr;
		avs_write <= wr;
		@(posedge clk);
		for (int n = 0; avs_waitrequest !== 1'b0; n++) begin
			if (n == 50) begin
				chk("bus wait", 0, 1);
				report_and_stop;
			end
			@(posedge clk);
		end
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge clk);
	endtask : bus
	// bounded wait: 0 ready, 1 full, 2 fast, 3 strobe
	task automatic wait_sig(input int sel, input logic lvl);
		logic [3:0] v;
		for (int n = 0; n < 5000; n++) begin
			@(posedge clk);
			v = {conversion_strobe, fast_power_down, full_power_down, ready};
			if (v[sel] === lvl) return;
		end
		chk("signal wait", lvl, ~lvl);
		report_and_stop;
	endtask : wait_sig
	task automatic frame(input logic [23:0] tx);
		i_host.xfer(tx, rx);
		@(posedge clk);
	endtask : frame
	// main sequence
	initial begin
		failures = 0;
		tests_run = 0;
		rst = 1'b1;
		shutdown_pin_n = 1'b1;
		shutdown_float = 1'b0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 4'h0;
		avs_writedata = 32'h0000_0000;
		avs_byteenable = 4'hf;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		chk("strobe", 1, conversion_strobe);
		chk("ready early", 0, ready);
		wait_sig(0, 1);
		bus(1, APS_REG_SAMPLE, {20'h0_0000, SMP});
		bus(0, APS_REG_SAMPLE, 32'h0000_0000);
		chk("sample", {20'h0_0000, SMP}, q);
		bus(0, 4'hc, 32'h0000_0000);
		chk("unmapped", 0, q);
		$display("test reset and registers done");
		frame({8'h83, 16'h0000});
		chk("first bits", 0, rx[23:16]);
		chk("ext data", {1'b0, SMP, 3'b000}, rx[15:0]);
		chk("stay on", 0, {full_power_down, fast_power_down});
		bus(0, APS_REG_CTRL, 32'h0000_0000);
		chk("control byte", 8'h83, q[7:0]);
		chk("strobe released", 1, conversion_strobe_oe_n);
		chk("dout released", 1, dout_oe_n);
		frame({8'h80, 16'h0000});
		chk("pd data", {1'b0, SMP, 3'b000}, rx[15:0]);
		wait_sig(1, 1);
		bus(0, APS_REG_STATUS, 32'h0000_0000);
		chk("status power", 2, q[3:2]);
		frame({8'h81, 16'h0000});
		wait_sig(2, 1);
		$display("test external modes done");
		frame({8'h82, 16'h0000});
		wait_sig(3, 0);
		wait_sig(3, 1);
		chk("int on", 0, {full_power_down, fast_power_down});
		chk("strobe driven", 0, conversion_strobe_oe_n);
		frame(24'h00_0000);
		chk("int data", SMP, rx[22:11]);
		frame({8'h80, 16'h0000});
		wait_sig(1, 1);
		frame(24'h00_0000);
		chk("pd read", SMP, rx[22:11]);
		$display("test internal modes done");
		frame({8'h83, 16'h0000});
		fork
			i_host.xfer({8'h83, 16'h0000}, rx);
			begin
				repeat (600) @(posedge clk);
				shutdown_pin_n <= 1'b0;
			end
		join
		@(posedge clk);
		chk("abort full", 1, full_power_down);
		frame({8'h83, 16'h0000});
		chk("shutdown held", 2'b10, {full_power_down, ready});
		shutdown_float <= 1'b1;
		shutdown_pin_n <= 1'b1;
		wait_sig(0, 1);
		bus(0, APS_REG_STATUS, 32'h0000_0000);
		chk("ext comp", 0, q[6]);
		shutdown_float <= 1'b0;
		repeat (4) @(posedge clk);
		bus(0, APS_REG_STATUS, 32'h0000_0000);
		chk("int comp", 1, q[6]);
		$display("test shutdown pin done");
		report_and_stop;
	end
endmodule : aps_adc_power_mode_sequencer_bench
`default_nettype wire
